// >>> src/scc_frac_div.sv
// Step over modulus fractional clock divider driven by 48 MHz reference ticks.
`timescale 1ns/1ps
module scc_frac_div
  import scc_pkg::*;
#(
  parameter int STEP_W = SCC_STEP_W,
  parameter int MOD_W = SCC_MOD_W
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, freezes state while low.
  input wire logic ref_tick, // One 48 MHz reference edge.
  input wire logic enable, // Output clock enable bit.
  input wire logic [STEP_W-1:0] step, // Step value.
  input wire logic [MOD_W-1:0] modulus, // Modulus value.
  output logic clk_out // Divided clock level.
);
  logic [MOD_W:0] acc;
  logic [MOD_W:0] sum;

  // Twice the step is added so that one wrap marks half a period and the output
  // frequency is 48 MHz times step over modulus; this needs modulus >= 2*step.
  assign sum = acc + {step, 1'b0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= '0;
      clk_out <= 1'b0;
    end else if (ce) begin
      if (!enable) begin // [RULE_12] [RULE_15]
        acc <= '0;
        clk_out <= 1'b0;
      end else if (ref_tick) begin
        if (sum >= {1'b0, modulus}) begin // [RULE_18] [RULE_13] [RULE_16]
          acc <= sum - {1'b0, modulus};
          clk_out <= ~clk_out;
        end else begin
          acc <= sum;
        end
      end
    end
  end
endmodule

// >>> src/scc_pkg.sv
// Package of register indices, field positions, reset values and divider constants for clock control.
// What this block does
// RULE_01: Bits 6:5 of system clock select choose the processor system clock source.
// RULE_02: Source code 00 RC 24 MHz, 01 fast, 10 divided fast, 11 32 MHz.
// RULE_03: The 32 MHz option passes two of every three 48 MHz ticks.
// RULE_04: Fast source selector is fast-source bit 0 above system select bit 7.
// RULE_05: Fast selector 00 is 48 MHz, 01 RC 24 MHz, 1x crystal pad 24 MHz.
// RULE_06: Divided option gives fast clock divided by the integer in bits 4:0.
// RULE_07: Software never writes divider value zero or one.
// RULE_08: Three module gate registers hold one clock gate bit per peripheral.
// RULE_09: A gate bit of one passes the module clock, zero blocks it.
// RULE_10: System timer clock is two thirds of crystal 24 MHz, fixed 16 MHz.
// RULE_11: Both crystal edges make the 48 MHz reference for audio and codec dividers.
// RULE_12: Audio serial clock runs only while its step register bit 7 is set.
// RULE_13: Audio serial clock equals 48 MHz times step over modulus.
// RULE_14: Software keeps the audio serial modulus at least twice its step.
// RULE_15: Codec clock runs only while its step register bit 7 is set.
// RULE_16: Codec clock equals 48 MHz times step over modulus.
// RULE_17: Software keeps the codec modulus at least twice its step.
// RULE_18: Each fractional divider accumulates modulo the modulus and toggles on every wrap.
// RULE_19: System clock switches only at an old-source edge, never making a short pulse; here a new edge can follow it by one pclk.
package scc_pkg;
  localparam int SCC_ADDR_W = 12;
  localparam logic [7:0] SCC_IDX_GATE0 = 8'h63;
  localparam logic [7:0] SCC_IDX_GATE1 = 8'h64;
  localparam logic [7:0] SCC_IDX_GATE2 = 8'h65;
  localparam logic [7:0] SCC_IDX_SYSSEL = 8'h66;
  localparam logic [7:0] SCC_IDX_AUD_STEP = 8'h67;
  localparam logic [7:0] SCC_IDX_AUD_MOD = 8'h68;
  localparam logic [7:0] SCC_IDX_COD_STEP = 8'h6C;
  localparam logic [7:0] SCC_IDX_COD_MOD = 8'h6D;
  localparam logic [7:0] SCC_IDX_FAST_HI = 8'h70;
  localparam logic [7:0] SCC_IDX_STATUS = 8'h74;
  localparam logic [7:0] SCC_RST_GATE0 = 8'h83;
  localparam logic [7:0] SCC_RST_GATE1 = 8'h00;
  localparam logic [7:0] SCC_RST_GATE2 = 8'h30;
  localparam logic [7:0] SCC_RST_SYSSEL = 8'h06;
  localparam logic [7:0] SCC_RST_AUD_STEP = 8'h00;
  localparam logic [7:0] SCC_RST_AUD_MOD = 8'h02;
  localparam logic [7:0] SCC_RST_COD_STEP = 8'h01;
  localparam logic [7:0] SCC_RST_COD_MOD = 8'h02;
  localparam logic SCC_RST_FAST_HI = 1'b0;
  localparam int SCC_SEL_FASTLO_BIT = 7;
  localparam int SCC_SEL_SRC_HI = 6;
  localparam int SCC_SEL_SRC_LO = 5;
  localparam int SCC_SEL_DIV_HI = 4;
  localparam int SCC_STEP_EN_BIT = 7;
  localparam int SCC_STEP_W = 7;
  localparam int SCC_MOD_W = 8;
  localparam int SCC_DIV_W = 5;
  localparam int SCC_GATE_N = 24;
  localparam logic [1:0] SCC_THIRDS_LAST = 2'h2;
  typedef enum logic [1:0] {
    SCC_SRC_RC = 2'b00,
    SCC_SRC_FAST = 2'b01,
    SCC_SRC_DIV = 2'b10,
    SCC_SRC_32M = 2'b11
  } scc_src_e;
endpackage

// >>> src/scc_top.sv
// System and module clock control with APB register access.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module scc_top
  import scc_pkg::*;
(
  input wire logic pclk, // System clock, 125 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, freezes all state while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [SCC_ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic internal_rc_clock, // RC 24 MHz oscillator level.
  input wire logic crystal_pad_clock, // Crystal 24 MHz level.
  output logic sys_clk_tick, // System clock edge strobe.
  output logic [SCC_GATE_N-1:0] module_clk_tick, // Gated module clock strobes.
  output logic timer_clk_tick, // 16 MHz system timer edge strobe.
  output logic audio_serial_clk, // Audio serial clock level.
  output logic codec_clk // Codec clock level.
);
  logic [7:0] module_gate_reg_zero;
  logic [7:0] module_gate_reg_one;
  logic [7:0] module_gate_reg_two;
  logic [7:0] system_clock_select_reg;
  logic [7:0] audio_serial_clock_step;
  logic [7:0] audio_serial_clock_modulus;
  logic [7:0] codec_divider_step;
  logic [7:0] codec_divider_modulus;
  logic fast_source_select_high;
  logic rc_dly;
  logic xtal_dly;
  logic rc_tick;
  logic pad_tick;
  logic ref48_tick;
  logic [1:0] third48_cnt;
  logic [1:0] third24_cnt;
  logic tick_32m;
  logic tick_16m;
  logic fast_tick;
  logic [SCC_DIV_W-1:0] div_cnt;
  logic div_tick;
  scc_src_e active_src;
  scc_src_e req_src;
  logic cur_tick;
  logic [SCC_GATE_N-1:0] gate_bits;
  logic [7:0] idx;
  logic idx_ok;
  logic acc_phase;
  logic [7:0] rd_byte;

  function automatic logic [7:0] addr_index(input logic [SCC_ADDR_W-1:0] a);
    addr_index = a[9:2];
  endfunction

  function automatic logic index_mapped(input logic [7:0] i);
    index_mapped = (i == SCC_IDX_GATE0) || (i == SCC_IDX_GATE1) || (i == SCC_IDX_GATE2) ||
                   (i == SCC_IDX_SYSSEL) || (i == SCC_IDX_AUD_STEP) ||
                   (i == SCC_IDX_AUD_MOD) || (i == SCC_IDX_COD_STEP) ||
                   (i == SCC_IDX_COD_MOD) || (i == SCC_IDX_FAST_HI) || (i == SCC_IDX_STATUS);
  endfunction

  // APB slave: always ready while enabled, so every access takes two cycles.
  assign idx = addr_index(paddr);
  assign idx_ok = index_mapped(idx) && (paddr[SCC_ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
  assign acc_phase = psel && penable && ce;
  assign pready = ce;
  assign pslverr = psel && penable && !idx_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_gate_reg_zero <= SCC_RST_GATE0;
      module_gate_reg_one <= SCC_RST_GATE1;
      module_gate_reg_two <= SCC_RST_GATE2;
      system_clock_select_reg <= SCC_RST_SYSSEL;
      audio_serial_clock_step <= SCC_RST_AUD_STEP;
      audio_serial_clock_modulus <= SCC_RST_AUD_MOD;
      codec_divider_step <= SCC_RST_COD_STEP;
      codec_divider_modulus <= SCC_RST_COD_MOD;
      fast_source_select_high <= SCC_RST_FAST_HI;
    end else if (acc_phase && pwrite && idx_ok) begin
      unique case (idx)
        SCC_IDX_GATE0: module_gate_reg_zero <= pwdata[7:0]; // [RULE_08]
        SCC_IDX_GATE1: module_gate_reg_one <= pwdata[7:0]; // [RULE_08]
        SCC_IDX_GATE2: module_gate_reg_two <= pwdata[7:0]; // [RULE_08]
        SCC_IDX_SYSSEL: system_clock_select_reg <= pwdata[7:0];
        SCC_IDX_AUD_STEP: audio_serial_clock_step <= pwdata[7:0];
        SCC_IDX_AUD_MOD: audio_serial_clock_modulus <= pwdata[7:0];
        SCC_IDX_COD_STEP: codec_divider_step <= pwdata[7:0];
        SCC_IDX_COD_MOD: codec_divider_modulus <= pwdata[7:0];
        SCC_IDX_FAST_HI: fast_source_select_high <= pwdata[0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      SCC_IDX_GATE0: rd_byte = module_gate_reg_zero;
      SCC_IDX_GATE1: rd_byte = module_gate_reg_one;
      SCC_IDX_GATE2: rd_byte = module_gate_reg_two;
      SCC_IDX_SYSSEL: rd_byte = system_clock_select_reg;
      SCC_IDX_AUD_STEP: rd_byte = audio_serial_clock_step;
      SCC_IDX_AUD_MOD: rd_byte = audio_serial_clock_modulus;
      SCC_IDX_COD_STEP: rd_byte = codec_divider_step;
      SCC_IDX_COD_MOD: rd_byte = codec_divider_modulus;
      SCC_IDX_FAST_HI: rd_byte = {7'h00, fast_source_select_high};
      SCC_IDX_STATUS: rd_byte = {3'h0, codec_clk, audio_serial_clk, (active_src != req_src),
                                 active_src};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data is registered in the setup cycle so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      prdata <= (!pwrite && idx_ok) ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  // Source levels are taken as synchronous; edges become one-cycle strobes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_dly <= 1'b0;
      xtal_dly <= 1'b0;
    end else if (ce) begin
      rc_dly <= internal_rc_clock;
      xtal_dly <= crystal_pad_clock;
    end
  end

  assign rc_tick = internal_rc_clock && !rc_dly;
  assign pad_tick = crystal_pad_clock && !xtal_dly;
  assign ref48_tick = crystal_pad_clock ^ xtal_dly; // [RULE_11]

  // Two of every three edges pass, so edge spacing stays bounded and the rate is 2/3.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      third48_cnt <= 2'h0;
      third24_cnt <= 2'h0;
    end else if (ce) begin
      if (ref48_tick) begin // [RULE_03]
        third48_cnt <= (third48_cnt == SCC_THIRDS_LAST) ? 2'h0 : third48_cnt + 2'h1;
      end
      if (pad_tick) begin // [RULE_10]
        third24_cnt <= (third24_cnt == SCC_THIRDS_LAST) ? 2'h0 : third24_cnt + 2'h1;
      end
    end
  end

  assign tick_32m = ref48_tick && (third48_cnt != SCC_THIRDS_LAST); // [RULE_03]
  assign tick_16m = pad_tick && (third24_cnt != SCC_THIRDS_LAST); // [RULE_10]

  always_comb begin
    unique case ({fast_source_select_high, system_clock_select_reg[SCC_SEL_FASTLO_BIT]})
      2'b00: fast_tick = ref48_tick; // [RULE_04] [RULE_05]
      2'b01: fast_tick = rc_tick; // [RULE_05]
      2'b10: fast_tick = pad_tick; // [RULE_05]
      2'b11: fast_tick = pad_tick; // [RULE_05]
    endcase
  end

  // Integer divider of the fast source; a divisor of 0 or 1 passes every edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (ce && fast_tick) begin
      if (div_tick) begin // [RULE_06]
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 5'h01;
      end
    end
  end

  assign div_tick = fast_tick &&
    ({1'b0, div_cnt} + 6'h01 >= {1'b0, system_clock_select_reg[SCC_SEL_DIV_HI:0]}); // [RULE_06]
  assign req_src = scc_src_e'(system_clock_select_reg[SCC_SEL_SRC_HI:SCC_SEL_SRC_LO]); // [RULE_01]

  always_comb begin
    unique case (active_src)
      SCC_SRC_RC: cur_tick = rc_tick; // [RULE_02]
      SCC_SRC_FAST: cur_tick = fast_tick; // [RULE_02]
      SCC_SRC_DIV: cur_tick = div_tick; // [RULE_02]
      SCC_SRC_32M: cur_tick = tick_32m; // [RULE_02]
    endcase
  end

  // A new source takes over only on an edge of the old one, so the first edge of the
  // new source can follow the last old edge by as little as one pclk cycle.
  // A stopped old source therefore also holds off the switch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_src <= SCC_SRC_RC;
    end else if (ce && cur_tick && (active_src != req_src)) begin
      active_src <= req_src; // [RULE_19]
    end
  end

  assign gate_bits = {module_gate_reg_two, module_gate_reg_one, module_gate_reg_zero};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_tick <= 1'b0;
      timer_clk_tick <= 1'b0;
    end else if (ce) begin
      sys_clk_tick <= cur_tick;
      timer_clk_tick <= tick_16m; // [RULE_10]
    end
  end

  for (genvar g = 0; g < SCC_GATE_N; g++) begin : g_gate
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        module_clk_tick[g] <= 1'b0;
      end else if (ce) begin
        module_clk_tick[g] <= cur_tick && gate_bits[g]; // [RULE_09]
      end
    end
  end

  scc_frac_div #(
    .STEP_W(SCC_STEP_W),
    .MOD_W(SCC_MOD_W)
  ) u_audio_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .ref_tick(ref48_tick),
    .enable(audio_serial_clock_step[SCC_STEP_EN_BIT]), // [RULE_12]
    .step(audio_serial_clock_step[SCC_STEP_W-1:0]), // [RULE_13]
    .modulus(audio_serial_clock_modulus),
    .clk_out(audio_serial_clk)
  );

  scc_frac_div #(
    .STEP_W(SCC_STEP_W),
    .MOD_W(SCC_MOD_W)
  ) u_codec_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .ref_tick(ref48_tick),
    .enable(codec_divider_step[SCC_STEP_EN_BIT]), // [RULE_15]
    .step(codec_divider_step[SCC_STEP_W-1:0]), // [RULE_16]
    .modulus(codec_divider_modulus),
    .clk_out(codec_clk)
  );
endmodule

// >>> tb/scc_top_props.sv
// Port-level checker for the clock control block.
`timescale 1ns/1ps
module scc_top_props
  import scc_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Write.
  input wire logic [SCC_ADDR_W-1:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic crystal_pad_clock, // Crystal level.
  input wire logic sys_clk_tick, // System tick.
  input wire logic [SCC_GATE_N-1:0] module_clk_tick, // Module ticks.
  input wire logic timer_clk_tick, // Timer tick.
  input wire logic audio_serial_clk, // Audio clock.
  input wire logic codec_clk // Codec clock.
);
  logic wr_ok;
  logic [23:0] gates;
  logic aud_en, cod_en, cr_q;
  logic [2:0] xr;
  assign wr_ok = psel && penable && pwrite && pready;
  // Shadow copies of the gate and enable bits, taken from completed writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gates <= {SCC_RST_GATE2, SCC_RST_GATE1, SCC_RST_GATE0};
      aud_en <= SCC_RST_AUD_STEP[7];
      cod_en <= SCC_RST_COD_STEP[7];
    end else if (wr_ok) begin
      if (paddr == {2'h0, SCC_IDX_GATE0, 2'h0}) gates[7:0] <= pwdata[7:0];
      if (paddr == {2'h0, SCC_IDX_GATE1, 2'h0}) gates[15:8] <= pwdata[7:0];
      if (paddr == {2'h0, SCC_IDX_GATE2, 2'h0}) gates[23:16] <= pwdata[7:0];
      if (paddr == {2'h0, SCC_IDX_AUD_STEP, 2'h0}) aud_en <= pwdata[7];
      if (paddr == {2'h0, SCC_IDX_COD_STEP, 2'h0}) cod_en <= pwdata[7];
    end
  end
  // Crystal rises since the last timer tick; two in three pass, so it never reaches three.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cr_q <= 1'b0;
      xr <= 3'h0;
    end else if (ce) begin
      cr_q <= crystal_pad_clock;
      if (timer_clk_tick) xr <= 3'h0;
      else if (crystal_pad_clock && !cr_q) xr <= xr + 3'h1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  gate_map_a: assert property (sys_clk_tick && $stable(gates) |-> module_clk_tick == gates)
    else $error("module ticks disagree with gate bits");
  gate_idle_a: assert property (!sys_clk_tick |-> module_clk_tick == '0)
    else $error("module tick without system tick");
  timer_rate_a: assert property (xr < 3'h3)
    else $error("timer skipped two crystal edges");
  aud_off_a: assert property (!aud_en && !$past(aud_en) |-> !audio_serial_clk)
    else $error("audio clock runs while disabled");
  cod_off_a: assert property (!cod_en && !$past(cod_en) |-> !codec_clk)
    else $error("codec clock runs while disabled");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  err_align_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  rd_upper_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  ready_ce_a: assert property (pready == ce)
    else $error("ready does not follow clock enable");
  cover property ($rose(audio_serial_clk));
  cover property ($rose(codec_clk));
  cover property (pslverr);
endmodule
bind scc_top scc_top_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .crystal_pad_clock(crystal_pad_clock),
  .sys_clk_tick(sys_clk_tick), .module_clk_tick(module_clk_tick),
  .timer_clk_tick(timer_clk_tick), .audio_serial_clk(audio_serial_clk), .codec_clk(codec_clk));

// >>> tb/scc_top_tb.sv
// Self-checking bench for the clock control block.
`timescale 1ns/1ps
module scc_top_tb
  import scc_pkg::*;
;
  localparam int XH = 3;
  localparam int RH = 5;
  localparam int WIN = 600;
  localparam int F48 = WIN / XH;
  localparam logic [7:0] RIDX [9] = '{SCC_IDX_GATE0, SCC_IDX_GATE1, SCC_IDX_GATE2,
    SCC_IDX_SYSSEL, SCC_IDX_AUD_STEP, SCC_IDX_AUD_MOD, SCC_IDX_COD_STEP, SCC_IDX_COD_MOD,
    SCC_IDX_FAST_HI};
  localparam logic [7:0] RVAL [9] = '{SCC_RST_GATE0, SCC_RST_GATE1, SCC_RST_GATE2,
    SCC_RST_SYSSEL, SCC_RST_AUD_STEP, SCC_RST_AUD_MOD, SCC_RST_COD_STEP, SCC_RST_COD_MOD,
    8'h00};
  // Every setting keeps a divider of two or more, even where the divided source is not chosen.
  localparam logic [7:0] CSEL [7] = '{8'h06, 8'h22, 8'hA2, 8'h22, 8'h44, 8'h42, 8'h62};
  localparam logic [7:0] CFST [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
  localparam int CEXP [7] = '{WIN / (2 * RH), F48, WIN / (2 * RH), F48 / 2, F48 / 4, F48 / 4,
    F48 * 2 / 3};
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, on;
  logic [SCC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rc, xtal, sys_t, tm_t, aud, cod, aud_q, cod_q;
  logic [SCC_GATE_N-1:0] mod_t;
  logic [7:0] g0, g2;
  int mismatches, checked, ph, n_sys, n_m0, n_m2, n_m20, n_tm, n_au, n_cd, x_sys, x_au, x_cd;
  scc_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_rc_clock(rc), .crystal_pad_clock(xtal), .sys_clk_tick(sys_t),
    .module_clk_tick(mod_t), .timer_clk_tick(tm_t), .audio_serial_clk(aud), .codec_clk(cod));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Oscillators are slower than pclk so that every level change is sampled.
  always @(posedge pclk) begin
    ph <= ph + 1;
    if (ph % XH == XH - 1) xtal <= ~xtal;
    if (ph % RH == RH - 1) rc <= ~rc;
    aud_q <= aud;
    cod_q <= cod;
    if (on) begin
      n_sys <= n_sys + (sys_t === 1'b1);
      n_m0 <= n_m0 + (mod_t[0] === 1'b1);
      n_m2 <= n_m2 + (mod_t[2] === 1'b1);
      n_m20 <= n_m20 + (mod_t[20] === 1'b1);
      n_tm <= n_tm + (tm_t === 1'b1);
      n_au <= n_au + (aud === 1'b1 && aud_q === 1'b0);
      n_cd <= n_cd + (cod === 1'b1 && cod_q === 1'b0);
    end
  end
  function automatic logic [SCC_ADDR_W-1:0] ad(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  task automatic wrap_up();
    $display("counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [SCC_ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp_val(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // Counts allow two edges of slack for where the window cuts the source phase.
  task automatic cmp_cnt(input string s, input int e, input int g);
    checked++;
    if (g < e - 2 || g > e + 2) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic measure(input string s);
    repeat (40) @(posedge pclk);
    {n_sys, n_m0, n_m2, n_m20, n_tm, n_au, n_cd} = '0;
    on <= 1'b1;
    repeat (WIN) @(posedge pclk);
    on <= 1'b0;
    @(posedge pclk);
    cmp_cnt("system ticks", x_sys, n_sys);
    cmp_cnt("module 0", g0[0] ? x_sys : 0, n_m0);
    cmp_cnt("module 2", g0[2] ? x_sys : 0, n_m2);
    cmp_cnt("module 20", g2[4] ? x_sys : 0, n_m20);
    cmp_cnt("timer", F48 / 3, n_tm);
    cmp_cnt("audio", x_au, n_au);
    cmp_cnt("codec", x_cd, n_cd);
    $display("test %s done", s);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, xtal, rc, on, aud_q, cod_q} = '0;
    {paddr, pwdata, ph, mismatches, checked, x_au, x_cd} = '0;
    ce = 1'b1;
    g0 = SCC_RST_GATE0;
    g2 = SCC_RST_GATE2;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ad(RIDX[i]), 8'h00);
      cmp_val("reset value", {24'h0, RVAL[i]}, rd);
    end
    apb(1'b1, ad(SCC_IDX_GATE1), 8'hA5);
    apb(1'b1, ad(SCC_IDX_GATE1) + 12'h1, 8'h00);
    cmp_val("misaligned error", 32'h1, {31'h0, err});
    apb(1'b0, ad(SCC_IDX_GATE1), 8'h00);
    cmp_val("gate 1 readback", 32'hA5, rd);
    apb(1'b1, ad(SCC_IDX_FAST_HI), 8'hFF);
    apb(1'b0, ad(SCC_IDX_FAST_HI), 8'h00);
    cmp_val("fast high bit", 32'h1, rd);
    apb(1'b0, ad(8'h71), 8'h00);
    cmp_val("unmapped error", 32'h1, {31'h0, err});
    cmp_val("unmapped data", 32'h0, rd);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ad(SCC_IDX_FAST_HI), CFST[i]);
      apb(1'b1, ad(SCC_IDX_SYSSEL), CSEL[i]);
      x_sys = CEXP[i];
      measure("source");
      apb(1'b0, ad(SCC_IDX_STATUS), 8'h00);
      cmp_val("active source", {30'h0, CSEL[i][6:5]}, rd);
    end
    g0 = 8'h04;
    g2 = 8'h00;
    apb(1'b1, ad(SCC_IDX_GATE0), g0);
    apb(1'b1, ad(SCC_IDX_GATE2), g2);
    measure("gates");
    apb(1'b1, ad(SCC_IDX_AUD_MOD), 8'h04);
    apb(1'b1, ad(SCC_IDX_AUD_STEP), 8'h81);
    apb(1'b1, ad(SCC_IDX_COD_MOD), 8'h08);
    apb(1'b1, ad(SCC_IDX_COD_STEP), 8'h83);
    x_au = F48 / 4;
    x_cd = F48 * 3 / 8;
    measure("fractional");
    apb(1'b1, ad(SCC_IDX_AUD_MOD), 8'h05);
    apb(1'b1, ad(SCC_IDX_AUD_STEP), 8'h82);
    apb(1'b1, ad(SCC_IDX_COD_STEP), 8'h03);
    x_au = F48 * 2 / 5;
    x_cd = 0;
    measure("codec off");
    // With the clock enable low every divider must hold its level, so no audio edge may appear.
    ce <= 1'b0;
    {n_sys, n_m0, n_m2, n_m20, n_tm, n_au, n_cd} = '0;
    on <= 1'b1;
    repeat (100) @(posedge pclk);
    on <= 1'b0;
    ce <= 1'b1;
    @(posedge pclk);
    cmp_cnt("frozen audio", 0, n_au);
    $display("test clock enable done");
    wrap_up();
  end
endmodule
